// ===== hsps_pkg.sv
package hsps_pkg;
  localparam int unsigned COLD_START_END_MV = 1300;
  typedef enum logic [5:0] {
    ST_COLD      = 6'h01,
    ST_BOOT      = 6'h02,
    ST_STS_CHG   = 6'h04,
    ST_LTS_CHG   = 6'h08,
    ST_JOINED    = 6'h10,
    ST_PROTECT   = 6'h20
  } hsps_state_e;
  localparam hsps_state_e STATE_RESET = ST_COLD;
endpackage

// ===== hsps_sequencer.sv
`timescale 1ns/100ps
module hsps_sequencer
  import hsps_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // short-term store comparators
  input wire logic sts_above_cold_start_end,
  input wire logic sts_above_min_high_sep,
  input wire logic sts_above_app_max_low,
  // long-term store comparators
  input wire logic lts_above_min_high_sep,
  input wire logic lts_above_min_high_joined,
  input wire logic lts_below_min_low,
  // joined storage comparators
  input wire logic stor_above_app_max_high,
  input wire logic stor_above_app_max_low,
  input wire logic stor_above_bat_max_high,
  input wire logic stor_below_bat_max_low,
  // harvester and converter control
  input wire logic harvester_no_energy,
  input wire logic converter_disable,
  // serial pads
  input wire logic chip_select,
  input wire logic serial_clk,
  input wire logic mosi_sda,
  input wire logic miso_data,
  // switches and converter
  output logic converter_run,
  output logic converter_tracking,
  output logic converter_to_lts,
  output logic stores_joined,
  output logic supply_direct,
  output logic supply_regulated,
  // status
  output logic energy_warning_flag,
  output logic energy_critical_flag,
  output logic harvester_low,
  output logic serial_enable,
  output logic spi_mode,
  output logic serial_clk_out,
  output logic serial_data_out,
  output logic miso
);
  // ----------------------------------------
  // sequencing state
  // ----------------------------------------
  hsps_state_e state;
  hsps_state_e next_state;
  logic ovp_stop;
  logic next_ovp_stop;
  logic next_tracking;
  logic supply_on;
  logic min_high;
  logic lts_min_ok;

  // effective min-high threshold follows connection state
  assign min_high = stores_joined ? lts_above_min_high_joined : sts_above_min_high_sep;
  // flags watch the long-term store itself, not the short-term one
  assign lts_min_ok = stores_joined ? lts_above_min_high_joined : lts_above_min_high_sep;
  // boot is sticky: a joined start waits for cold-start end before tracking
  assign next_tracking = converter_tracking || sts_above_cold_start_end;

  always_comb begin
    next_state = state;
    case (state)
      ST_COLD: begin
        // a charged long-term store joins immediately
        if (lts_above_min_high_sep) begin
          next_state = ST_JOINED;
        end else if (sts_above_cold_start_end) begin
          next_state = ST_BOOT;
        end
      end
      ST_BOOT: begin
        if (lts_above_min_high_sep) begin
          next_state = ST_JOINED;
        end else if (sts_above_app_max_low) begin
          next_state = ST_LTS_CHG;
        end else begin
          next_state = ST_STS_CHG;
        end
      end
      ST_STS_CHG: begin
        if (lts_above_min_high_sep) begin
          next_state = ST_JOINED;
        end else if (sts_above_app_max_low) begin
          next_state = ST_LTS_CHG;
        end
      end
      ST_LTS_CHG: begin
        if (lts_above_min_high_sep) begin
          next_state = ST_JOINED;
        end else if (!sts_above_min_high_sep) begin
          next_state = ST_STS_CHG;
        end
      end
      ST_JOINED: begin
        if (lts_below_min_low) begin
          next_state = ST_PROTECT;
        end
      end
      ST_PROTECT: begin
        // separated stores recharge from the converter only
        if (lts_above_min_high_sep) begin
          next_state = ST_JOINED;
        end else if (sts_above_app_max_low) begin
          next_state = ST_LTS_CHG;
        end
      end
      default: begin
        next_state = STATE_RESET;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      state <= STATE_RESET;
    end else begin
      state <= next_state;
    end
  end

  // ----------------------------------------
  // overvoltage hysteresis
  // ----------------------------------------
  // next value used by the converter too, so the stop costs no extra cycle
  always_comb begin
    next_ovp_stop = ovp_stop;
    if (stor_above_bat_max_high) begin
      next_ovp_stop = 1'b1;
    end else if (stor_below_bat_max_low) begin
      next_ovp_stop = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      ovp_stop <= 1'b0;
    end else begin
      ovp_stop <= next_ovp_stop;
    end
  end

  // ----------------------------------------
  // converter and switches
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (srst) begin
      converter_run <= 1'b0;
      converter_tracking <= 1'b0;
      converter_to_lts <= 1'b0;
      stores_joined <= 1'b0;
    end else begin
      // cold-start converter runs unless disabled or stopped by overvoltage, steered to short-term store
      converter_run <= !converter_disable && !next_ovp_stop;
      converter_tracking <= next_tracking;
      converter_to_lts <= (next_state == ST_LTS_CHG) && next_tracking;
      stores_joined <= (next_state == ST_JOINED);
    end
  end

  // main supply: direct below app max, regulated above it
  always_ff @(posedge clk) begin
    if (srst) begin
      supply_on <= 1'b0;
    end else if (state == ST_COLD) begin
      supply_on <= 1'b0;
    end else if (state == ST_JOINED) begin
      // joined start: supply only once booted
      supply_on <= converter_tracking;
    end else if (min_high) begin
      supply_on <= 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      supply_direct <= 1'b0;
      supply_regulated <= 1'b0;
    end else if (!supply_on) begin
      // both switches stay open while the main supply is off
      supply_direct <= 1'b0;
      supply_regulated <= 1'b0;
    end else if (stor_above_app_max_high) begin
      supply_direct <= 1'b0;
      supply_regulated <= 1'b1;
    end else if (!stor_above_app_max_low) begin
      supply_direct <= 1'b1;
      supply_regulated <= 1'b0;
    end
  end

  // ----------------------------------------
  // status flags
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (srst) begin
      energy_warning_flag <= 1'b0;
      energy_critical_flag <= 1'b0;
      harvester_low <= 1'b0;
    end else begin
      // warning: critical high alone; shutdown: both high
      energy_critical_flag <= !lts_min_ok;
      energy_warning_flag <= lts_below_min_low;
      harvester_low <= harvester_no_energy;
    end
  end

  // ----------------------------------------
  // serial pads, gated by main supply
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (srst) begin
      serial_enable <= 1'b0;
      spi_mode <= 1'b0;
      serial_clk_out <= 1'b0;
      serial_data_out <= 1'b0;
      miso <= 1'b0;
    end else begin
      // pads float without supply, so nothing passes then
      serial_enable <= supply_on;
      spi_mode <= supply_on && chip_select;
      serial_clk_out <= supply_on && serial_clk;
      serial_data_out <= supply_on && mosi_sda;
      miso <= supply_on && chip_select && miso_data;
    end
  end
endmodule

// ===== hsps_seq_properties.sv
`timescale 1ns/100ps
// ------------------
// sequencer checks
// ------------------
module hsps_seq_properties (
  input wire logic clk, srst, converter_disable, harvester_no_energy,
  input wire logic sts_above_cold_start_end, lts_below_min_low, stor_above_bat_max_high,
  input wire logic converter_run, converter_tracking, converter_to_lts, stores_joined,
  input wire logic supply_direct, supply_regulated, energy_warning_flag, harvester_low,
  input wire logic serial_enable, serial_clk_out, serial_data_out, miso
);
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  sequence s_cold_end;
    !converter_tracking && sts_above_cold_start_end;
  endsequence
  sequence s_unpowered;
    !serial_enable [*2];
  endsequence
  a_cold_steer: assert property (!converter_tracking |-> !converter_to_lts)
    else $error("converter steered to long-term store in cold start");
  a_boot_track: assert property (s_cold_end |=> converter_tracking)
    else $error("no tracking after cold-start end");
  a_ovp_stop: assert property (stor_above_bat_max_high |=> !converter_run)
    else $error("converter runs above max-high");
  a_disable_stop: assert property (converter_disable |=> !converter_run)
    else $error("converter runs while disabled");
  a_harv_low: assert property (
    !$past(srst) |-> harvester_low == $past(harvester_no_energy))
    else $error("harvester-low does not follow comparator");
  a_flag_low: assert property (
    !$past(srst) |-> energy_warning_flag == $past(lts_below_min_low))
    else $error("min-low flag does not follow comparator");
  a_protect_split: assert property (lts_below_min_low |=> !stores_joined)
    else $error("stores joined below min-low");
  a_pads_gated: assert property (
    s_unpowered |-> !(serial_clk_out || serial_data_out || miso))
    else $error("serial pads active with supply off");
  a_supply_mode: assert property (!(supply_direct && supply_regulated))
    else $error("supply both direct and regulated");
endmodule
bind hsps_sequencer hsps_seq_properties i_chk (.*);

// ===== hsps_host_model.sv
`timescale 1ns/100ps
module hsps_host_model (
  input wire logic clk,
  input wire logic go,
  input wire logic serial_enable,
  input wire logic energy_critical_flag,
  output logic chip_select,
  output logic serial_clk,
  output logic mosi_sda,
  output logic shed_load
);
  logic t = 1'h0;
  always @(negedge clk) t <= ~t;
  assign chip_select = go;
  // clock only within a frame
  assign serial_clk = go & t;
  // unpowered pads float: wiggle so no clean level is seen
  assign mosi_sda = serial_enable ? go : t;
  // host sheds its load on the first warning and at shutdown
  assign shed_load = energy_critical_flag;
endmodule

// ===== harvester_storage_power_sequencer_test.sv
`timescale 1ns/100ps
module harvester_storage_power_sequencer_test;
  import hsps_pkg::*;
  logic clk = 1'h0, srst = 1'h1, go = 1'h0, miso_data = 1'h1, chip_select, serial_clk, mosi_sda;
  logic sts_above_cold_start_end, sts_above_min_high_sep, sts_above_app_max_low;
  logic lts_above_min_high_sep, lts_above_min_high_joined, lts_below_min_low;
  logic stor_above_app_max_high, stor_above_app_max_low, stor_above_bat_max_high;
  logic stor_below_bat_max_low, harvester_no_energy, converter_disable;
  logic converter_run, converter_tracking, converter_to_lts, stores_joined;
  logic supply_direct, supply_regulated, energy_warning_flag, energy_critical_flag;
  logic harvester_low, serial_enable, spi_mode, serial_clk_out, serial_data_out, miso;
  logic shed_load;
  int error_cnt = 0;
  int compares = 0;
  hsps_sequencer i_hsps_sequencer (.*);
  hsps_host_model i_hsps_host_model (.clk(clk), .go(go), .serial_enable(serial_enable),
    .energy_critical_flag(energy_critical_flag), .chip_select(chip_select),
    .serial_clk(serial_clk), .mosi_sda(mosi_sda), .shed_load(shed_load));
  always #12.5 clk = ~clk;
  task chk(input string n, input logic s, input logic e);
    compares++;
    if (s !== e) begin
      error_cnt++;
      $display("MISMATCH %s expected %b seen %b", n, e, s);
    end
  endtask
  task summarize;
    if (error_cnt == 0 && compares > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task step(input int n);
    repeat (n) @(negedge clk);
  endtask
  task start(input logic lts);
    {sts_above_min_high_sep, sts_above_app_max_low, lts_above_min_high_joined} = 3'h0;
    {lts_below_min_low, stor_above_app_max_low, stor_above_bat_max_high} = 3'h0;
    {stor_below_bat_max_low, harvester_no_energy, converter_disable} = 3'h0;
    {lts_above_min_high_sep, stor_above_app_max_high, sts_above_cold_start_end} = 3'h0;
    srst = 1'h1;
    step(2);
    srst = 1'h0;
    step(1);
    {lts_above_min_high_sep, stor_above_app_max_high, stor_above_app_max_low} = {3{lts}};
    // a long-term start joins first and only boots at cold-start end
    sts_above_cold_start_end = !lts;
  endtask
  // ------------
  // main sequence
  // ------------
  initial begin
    start(1'h0);
    go = 1'h1;
    step(2);
    chk("tracking", converter_tracking, 1'h1);
    chk("to_lts", converter_to_lts, 1'h0);
    chk("sclk_gated", serial_clk_out, 1'h0);
    chk("sdo_gated", serial_data_out, 1'h0);
    chk("miso_gated", miso, 1'h0);
    chk("ser_off", serial_enable, 1'h0);
    sts_above_min_high_sep = 1'h1;
    step(4);
    chk("direct", supply_direct, 1'h1);
    chk("spi", spi_mode, 1'h1);
    chk("ser_on", serial_enable, 1'h1);
    chk("sdo", serial_data_out, 1'h1);
    chk("miso", miso, 1'h1);
    sts_above_app_max_low = 1'h1;
    step(3);
    chk("to_lts", converter_to_lts, 1'h1);
    {sts_above_app_max_low, sts_above_min_high_sep, go} = 3'h0;
    step(3);
    chk("to_sts", converter_to_lts, 1'h0);
    chk("i2c", spi_mode, 1'h0);
    {sts_above_min_high_sep, lts_above_min_high_sep, lts_above_min_high_joined, go} = 4'hf;
    step(3);
    chk("joined", stores_joined, 1'h1);
    chk("crit_clear", energy_critical_flag, 1'h0);
    chk("no_shed", shed_load, 1'h0);
    {stor_above_app_max_low, stor_above_app_max_high} = 2'h3;
    step(4);
    chk("regulated", supply_regulated, 1'h1);
    stor_above_bat_max_high = 1'h1;
    step(3);
    chk("ovp", converter_run, 1'h0);
    stor_above_bat_max_high = 1'h0;
    step(3);
    chk("hyst", converter_run, 1'h0);
    stor_below_bat_max_low = 1'h1;
    step(3);
    chk("restart", converter_run, 1'h1);
    converter_disable = 1'h1;
    step(3);
    chk("disabled", converter_run, 1'h0);
    {converter_disable, harvester_no_energy} = 2'h1;
    step(2);
    chk("hrv_low", harvester_low, 1'h1);
    {lts_above_min_high_joined, lts_above_min_high_sep} = 2'h0;
    step(3);
    chk("warn", energy_warning_flag, 1'h0);
    chk("crit", energy_critical_flag, 1'h1);
    chk("shed", shed_load, 1'h1);
    lts_below_min_low = 1'h1;
    step(3);
    chk("shutdown", energy_warning_flag, 1'h1);
    chk("shutdown_crit", energy_critical_flag, 1'h1);
    chk("split", stores_joined, 1'h0);
    start(1'h1);
    step(2);
    chk("lts_join", stores_joined, 1'h1);
    chk("no_boot", converter_tracking, 1'h0);
    chk("no_supply", supply_regulated, 1'h0);
    sts_above_cold_start_end = 1'h1;
    step(4);
    chk("reg_start", supply_regulated, 1'h1);
    chk("no_direct", supply_direct, 1'h0);
    summarize();
  end
  initial begin
    #50000;
    error_cnt++;
    summarize();
  end
endmodule
